/* common/irqvm_pkg.sv */
package irqvm_pkg;

    // sizes
    localparam int NUM_IRQ     = 39;
    localparam int NUM_VEC     = 32;
    localparam int NUM_PRI_REG = 8;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    localparam int HIGH_IRQS   = 7;

    // register byte offsets
    localparam logic [7:0] OFS_FLAG_LOW   = 8'h00;
    localparam logic [7:0] OFS_FLAG_HIGH  = 8'h04;
    localparam logic [7:0] OFS_EN_LOW     = 8'h08;
    localparam logic [7:0] OFS_EN_HIGH    = 8'h0c;
    localparam logic [7:0] OFS_PRI_FIRST  = 8'h10;
    localparam logic [7:0] OFS_PRI_LAST   = 8'h2c;
    localparam logic [7:0] OFS_VEC_STATUS = 8'h30;

    // priority register layout: four slots of eight bits
    localparam int         SLOT_W        = 8;
    localparam int         PRI_LSB       = 2;
    localparam int         SUB_LSB       = 0;
    localparam int         FIELD_W       = 5;
    localparam logic [31:0] PRI_FIELD_MASK = 32'h1f1f1f1f;

    // vector status register layout
    localparam int VS_VEC_LSB = 0;
    localparam int VS_PRI_LSB = 8;
    localparam int VS_SUB_LSB = 12;
    localparam int VS_VALID   = 31;

    // reset values
    localparam logic [38:0] FLAG_RST = 39'h00_0000_0000;
    localparam logic [38:0] EN_RST   = 39'h00_0000_0000;
    localparam logic [31:0] PRI_RST  = 32'h0000_0000;

    // source positions inside the request vector
    localparam int CORE_TICK_REQUEST          = 0;
    localparam int CORE_SOFT_REQUEST_ZERO     = 1;
    localparam int CORE_SOFT_REQUEST_ONE      = 2;
    localparam int EXT_PIN_REQUEST_ZERO       = 3;
    localparam int CAPTURE_ONE_ERROR_REQUEST  = 5;
    localparam int CAPTURE_ONE_REQUEST        = 6;
    localparam int COMPARE_ONE_REQUEST        = 7;
    localparam int ADC_DONE_REQUEST           = 28;
    localparam int CLOCK_FAIL_MONITOR_REQUEST = 29;
    localparam int CALENDAR_CLOCK_REQUEST     = 30;
    localparam int FLASH_EVENT_REQUEST        = 31;
    localparam int COMPARATOR_ONE_REQUEST     = 32;
    localparam int USB_REQUEST                = 35;
    localparam int SPI_ONE_FAULT_REQUEST      = 36;
    localparam int SPI_ONE_RX_REQUEST         = 37;
    localparam int SPI_ONE_TX_REQUEST         = 38;

    // sources that hold their flag while the condition stays
    localparam logic [38:0] PERSIST_MASK = 39'h78_1631_8c60;

    typedef logic [4:0] irqvm_vec_t;

    // irq number to vector number
    localparam irqvm_vec_t IRQ_TO_VEC [NUM_IRQ] = '{
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h05, 5'h06,
        5'h07, 5'h08, 5'h09, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
        5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h11, 5'h12, 5'h13,
        5'h14, 5'h15, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1a,
        5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h1f, 5'h1f
    };

endpackage : irqvm_pkg

/* common/irqvm_arb_if.sv */
interface irqvm_arb_if;
    logic [31:0]       vec_pend;
    logic [7:0][31:0]  pri_regs;
    logic              win_valid;
    logic [4:0]        win_vec;
    logic [2:0]        win_pri;
    logic [1:0]        win_sub;

    modport ctrl (
        output vec_pend,
        output pri_regs,
        input  win_valid,
        input  win_vec,
        input  win_pri,
        input  win_sub
    );

    modport arb (
        input  vec_pend,
        input  pri_regs,
        output win_valid,
        output win_vec,
        output win_pri,
        output win_sub
    );
endinterface : irqvm_arb_if

/* hdl/irqvm_arbiter.sv */
module irqvm_arbiter (
    // pending vectors in, winner out
    irqvm_arb_if.arb arb_if
);

    function automatic logic [4:0] field_of(input logic [7:0][31:0] regs, input int v);
        logic [31:0] r;
        r = regs[v / 4];
        return r[(v % 4) * irqvm_pkg::SLOT_W +: irqvm_pkg::FIELD_W];
    endfunction : field_of

    always_comb begin
        logic       found;
        logic [4:0] best;
        logic [4:0] best_vec;
        logic [4:0] f;
        found    = 1'b0;
        best     = 5'h00;
        best_vec = 5'h00;
        f        = 5'h00;
        for (int v = 0; v < irqvm_pkg::NUM_VEC; v++) begin
            f = field_of(arb_if.pri_regs, v);
            // priority zero keeps the vector quiet; strict compare lets the lower vector win a tie
            if (arb_if.vec_pend[v] && (f[4:2] != 3'h0) && (!found || (f > best))) begin // see RL13
                found    = 1'b1;
                best     = f;
                best_vec = v[4:0];
            end
        end
        arb_if.win_valid = found;
        arb_if.win_vec   = best_vec;
        arb_if.win_pri   = best[4:2];
        arb_if.win_sub   = best[1:0];
    end

endmodule : irqvm_arbiter

/* hdl/irqvm_top.sv */
// How it works
// RL1: each irq owns flag and enable bit at its number; 32 up use high regs
// RL2: per vector three-bit priority and two-bit sub-priority, four slots per register
// RL3: core tick irq 0 vector 0; soft requests irqs 1,2 vectors 1,2; edge type
// RL4: external pins 0-4 on irqs 3,8,13,18,23, vectors 3,7,11,15,19; edge type
// RL5: capture error and capture event: own irqs, shared vector and priority; level type
// RL6: compare units 1-5 on irqs 7,12,17,22,27, vectors 6,10,14,18,22; edge type
// RL7: adc done irq 28 vector 23, level type
// RL8: clock fail 29/24, calendar 30/25, flash 31/26; private vectors, edge type
// RL9: comparators 1-3 on irqs 32-34, vectors 27-29, high reg bits 0-2
// RL10: usb irq 35 vector 30, high reg bit 3, level type
// RL11: spi fault, rx, tx on irqs 36-38, shared vector 31, level type
// RL12: sources absent in a variant have no flag, enable or request
// RL13: equal priority and sub-priority: lowest vector number served first
// RL14: level sources set their flag again while the condition remains after a clear
module irqvm_top #(
    parameter logic [38:0] IRQ_PRESENT = 39'h7f_ffff_ffff
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // peripheral request lines, one per irq number
    input  wire logic [38:0] src_req_i,
    // towards the core
    output logic             irq_o,
    output logic             vec_req_o,
    output logic      [4:0]  vec_num_o,
    output logic      [2:0]  vec_pri_o,
    output logic      [1:0]  vec_sub_o
);

    typedef struct packed {
        logic [38:0]      flag;
        logic [38:0]      en;
        logic [7:0][31:0] pri;
        logic [38:0]      src_prev;
        logic [31:0]      rdata;
        logic             irq;
        logic             vreq;
        logic [4:0]       vnum;
        logic [2:0]       vpri;
        logic [1:0]       vsub;
    } irqvm_state_t;

    localparam irqvm_state_t STATE_RST = '{
        flag:     irqvm_pkg::FLAG_RST,
        en:       irqvm_pkg::EN_RST,
        pri:      {irqvm_pkg::NUM_PRI_REG{irqvm_pkg::PRI_RST}},
        src_prev: 39'h00_0000_0000,
        rdata:    32'h0000_0000,
        irq:      1'b0,
        vreq:     1'b0,
        vnum:     5'h00,
        vpri:     3'h0,
        vsub:     2'h0
    };

    irqvm_state_t st_ff;
    irqvm_state_t nxt_st;

    irqvm_arb_if arb_if ();

    irqvm_arbiter u_arbiter (
        .arb_if (arb_if.arb)
    );

    // priority register window decode, shared by read and write
    function automatic logic is_pri_addr(input logic [7:0] a);
        return (a >= irqvm_pkg::OFS_PRI_FIRST) && (a <= irqvm_pkg::OFS_PRI_LAST) && (a[1:0] == 2'h0);
    endfunction : is_pri_addr

    function automatic logic [2:0] pri_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - irqvm_pkg::OFS_PRI_FIRST;
        return d[4:2];
    endfunction : pri_index

    // pending vectors: enabled flags folded onto their vectors
    always_comb begin
        logic [38:0] act;
        act = st_ff.flag & st_ff.en & IRQ_PRESENT;
        arb_if.vec_pend = 32'h0000_0000;
        for (int i = 0; i < irqvm_pkg::NUM_IRQ; i++) begin
            if (act[i]) begin
                arb_if.vec_pend[irqvm_pkg::IRQ_TO_VEC[i]] = 1'b1; // see RL3 see RL4 see RL5 see RL6 see RL11
            end
        end
        arb_if.pri_regs = st_ff.pri; // see RL2
    end

    always_comb begin
        logic [38:0] rise;
        logic [38:0] set;
        logic [38:0] clr;
        logic [31:0] rd_val;
        nxt_st = st_ff;
        rise   = src_req_i & ~st_ff.src_prev;
        clr    = 39'h00_0000_0000;
        rd_val = 32'h0000_0000;

        // level sources set each cycle the line is high, others on a rising edge
        set = ((irqvm_pkg::PERSIST_MASK & src_req_i) | (~irqvm_pkg::PERSIST_MASK & rise)) // see RL7 see RL10 see RL14
            & IRQ_PRESENT; // see RL12
        nxt_st.src_prev = src_req_i; // see RL8 see RL9

        // register writes
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                irqvm_pkg::OFS_FLAG_LOW: begin
                    clr[31:0] = reg_wdata_i; // see RL1
                end
                irqvm_pkg::OFS_FLAG_HIGH: begin
                    clr[38:32] = reg_wdata_i[irqvm_pkg::HIGH_IRQS-1:0]; // see RL1
                end
                irqvm_pkg::OFS_EN_LOW: begin
                    nxt_st.en[31:0] = reg_wdata_i;
                end
                irqvm_pkg::OFS_EN_HIGH: begin
                    nxt_st.en[38:32] = reg_wdata_i[irqvm_pkg::HIGH_IRQS-1:0];
                end
                default: begin
                    if (is_pri_addr(reg_addr_i)) begin
                        nxt_st.pri[pri_index(reg_addr_i)] = reg_wdata_i & irqvm_pkg::PRI_FIELD_MASK; // see RL2
                    end
                end
            endcase
        end

        // a set in the same cycle as a clear wins
        nxt_st.flag = ((st_ff.flag & ~clr) | set) & IRQ_PRESENT; // see RL14 see RL12
        nxt_st.en   = nxt_st.en & IRQ_PRESENT; // see RL12

        // level interrupt while any enabled flag stands
        nxt_st.irq = |(nxt_st.flag & nxt_st.en);

        // winner towards the core
        nxt_st.vreq = arb_if.win_valid;
        nxt_st.vnum = arb_if.win_vec;
        nxt_st.vpri = arb_if.win_pri;
        nxt_st.vsub = arb_if.win_sub;

        // register reads, data stand one cycle
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                irqvm_pkg::OFS_FLAG_LOW: begin
                    rd_val = st_ff.flag[31:0];
                end
                irqvm_pkg::OFS_FLAG_HIGH: begin
                    rd_val[irqvm_pkg::HIGH_IRQS-1:0] = st_ff.flag[38:32];
                end
                irqvm_pkg::OFS_EN_LOW: begin
                    rd_val = st_ff.en[31:0];
                end
                irqvm_pkg::OFS_EN_HIGH: begin
                    rd_val[irqvm_pkg::HIGH_IRQS-1:0] = st_ff.en[38:32];
                end
                irqvm_pkg::OFS_VEC_STATUS: begin
                    rd_val[irqvm_pkg::VS_VEC_LSB +: 5] = st_ff.vnum;
                    rd_val[irqvm_pkg::VS_PRI_LSB +: 3] = st_ff.vpri;
                    rd_val[irqvm_pkg::VS_SUB_LSB +: 2] = st_ff.vsub;
                    rd_val[irqvm_pkg::VS_VALID]        = st_ff.vreq;
                end
                default: begin
                    if (is_pri_addr(reg_addr_i)) begin
                        rd_val = st_ff.pri[pri_index(reg_addr_i)];
                    end
                end
            endcase
        end
        nxt_st.rdata = rd_val;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_ff <= STATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_o = st_ff.rdata;
    assign irq_o       = st_ff.irq;
    assign vec_req_o   = st_ff.vreq;
    assign vec_num_o   = st_ff.vnum;
    assign vec_pri_o   = st_ff.vpri;
    assign vec_sub_o   = st_ff.vsub;

endmodule : irqvm_top

/* testbench/irqvm_top_asserts.sv */
module irqvm_top_asserts (
    // watched ports
    input wire logic        core_clk_i,
    input wire logic        sys_rst_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [38:0] src_req_i,
    input wire logic        irq_o,
    input wire logic        vec_req_o,
    input wire logic [4:0]  vec_num_o,
    input wire logic [2:0]  vec_pri_o,
    input wire logic [1:0]  vec_sub_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; $past(reg_rd_i) && $past(reg_addr_i) > 8'h30 |-> reg_rdata_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pri_mask;
        $past(reg_rd_i) && $past(reg_addr_i) inside {[8'h10:8'h2c]} |->
            (reg_rdata_o & ~irqvm_pkg::PRI_FIELD_MASK) == 32'h0;
    endproperty
    a_pri_mask: assert property (p_pri_mask) else $error("priority read outside fields");
    property p_high_mask; $past(reg_rd_i) && $past(reg_addr_i) inside {8'h04, 8'h0c} |-> reg_rdata_o[31:7] == '0; endproperty
    a_high_mask: assert property (p_high_mask) else $error("high register spare bits set");
    property p_status;
        $past(reg_rd_i) && $past(reg_addr_i) == 8'h30 |-> reg_rdata_o[31] == $past(vec_req_o) &&
            (!reg_rdata_o[31] || reg_rdata_o[13:0] == {$past(vec_sub_o), 1'b0, $past(vec_pri_o), 3'h0, $past(vec_num_o)});
    endproperty
    a_status: assert property (p_status) else $error("status differs from vector outputs");
    property p_vec_pri; vec_req_o |-> vec_pri_o != 3'h0 && $past(irq_o); endproperty
    a_vec_pri: assert property (p_vec_pri) else $error("vector request without cause");
    property p_irq_fall; $fell(irq_o) |-> $past(reg_wr_i) || $past(sys_rst_i); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
    property p_irq_rise; $rose(irq_o) |-> $past(reg_wr_i) || $past(|src_req_i); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt raised without cause");
    property p_rst_quiet; $past(sys_rst_i) |-> !irq_o && !vec_req_o && reg_rdata_o == 32'h0; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");

    c_vec: cover property ($rose(vec_req_o));
    c_fall: cover property ($fell(irq_o));
    c_stat: cover property (reg_rd_i && reg_addr_i == 8'h30);
endmodule : irqvm_top_asserts

bind irqvm_top irqvm_top_asserts u_asserts (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i), .irq_o(irq_o),
    .vec_req_o(vec_req_o), .vec_num_o(vec_num_o), .vec_pri_o(vec_pri_o), .vec_sub_o(vec_sub_o)
);

/* testbench/irqvm_core_model.sv */
module irqvm_core_model (
    // vector requests from the controller
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       vec_req_i,
    input  wire logic [4:0] vec_num_i,
    // last vector taken
    output logic      [4:0] last_vec_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // core takes the winning vector whenever one is offered
    always @(posedge core_clk_i) begin
        if (sys_rst_i)
            last_vec_o <= 5'h00;
        else if (vec_req_i)
            last_vec_o <= vec_num_i;
    end
endmodule : irqvm_core_model

/* testbench/irq_vector_mapping_tb.sv */
module irq_vector_mapping_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, irq_o, vec_req_o;
    logic [7:0]  reg_addr_i, hi, pa;
    logic [31:0] reg_wdata_i, reg_rdata_o, d, bm, pv, lf;
    logic [38:0] src_req_i;
    logic [4:0]  vec_num_o, last_vec, v;
    logic [2:0]  vec_pri_o, p;
    logic [1:0]  vec_sub_o, s;
    int          n_mismatch, tests_run;
    // variant built without the usb source
    localparam logic [38:0] VAR_PRESENT = 39'h77_ffff_ffff;
    logic [31:0] rdata_var, dv;
    logic        irq_var;

    irqvm_top uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .src_req_i(src_req_i), .irq_o(irq_o), .vec_req_o(vec_req_o), .vec_num_o(vec_num_o),
        .vec_pri_o(vec_pri_o), .vec_sub_o(vec_sub_o));
    irqvm_core_model core (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .vec_req_i(vec_req_o),
        .vec_num_i(vec_num_o), .last_vec_o(last_vec));
    irqvm_top #(.IRQ_PRESENT(VAR_PRESENT)) uut_var (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata_var), .src_req_i(src_req_i), .irq_o(irq_var), .vec_req_o(), .vec_num_o(),
        .vec_pri_o(), .vec_sub_o());

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [4:0] exp_vec(input int n);
        if (n <= 5) return 5'(n);
        if (n <= 28) return 5'(n - 1 - (n - 6) / 5);
        if (n <= 35) return 5'(n - 5);
        return 5'h1f;
    endfunction : exp_vec
    function automatic logic persist(input int n);
        return (n >= 5 && n <= 26 && n % 5 < 2) || n == 28 || n >= 35;
    endfunction : persist

    task automatic test_done();
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= x;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        x = reg_rdata_o;
        dv = rdata_var;
    endtask : rd

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_mismatch++;
        test_done();
    end

    initial begin
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, src_req_i} = '0;
        sys_rst_i = 1'b1;
        lf = 32'h4c313497;
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        wr(8'h40, 32'hffff_ffff);
        for (int a = 0; a <= 8'h40; a += 4) begin
            rd(8'(a), d);
            chk(d, 32'h0);
        end
        wr(8'h2c, 32'hffff_ffff);
        rd(8'h2c, d);
        chk(d, 32'h1f1f_1f1f);
        wr(8'h2c, 32'h0);
        for (int n = 0; n < 39; n++) begin
            v = exp_vec(n);
            hi = n >= 32 ? 8'h04 : 8'h00;
            bm = 32'h1 << (n % 32);
            lf = lfsr(lf);
            p = (lf[2:0] == 3'h0) ? 3'h4 : lf[2:0];
            s = lf[4:3];
            pa = 8'h10 + 8'(4 * (v / 4));
            pv = 32'({p, s}) << (8 * (v % 4));
            wr(pa, pv);
            @(posedge core_clk_i);
            src_req_i <= 39'h1 << n;
            repeat (2 + lf[6:5]) @(posedge core_clk_i);
            rd(hi, d);
            chk(d, bm);
            chk(dv, VAR_PRESENT[n] ? bm : 32'h0);
            chk(32'(irq_o), 32'h0);
            wr(hi + 8'h08, bm);
            @(negedge core_clk_i);
            chk(32'(irq_o), 32'h1);
            chk(32'(irq_var), 32'(VAR_PRESENT[n]));
            rd(8'h30, d);
            chk(d, 32'h8000_0000 | 32'({s, 1'b0, p, 3'h0, v}));
            chk(32'({vec_pri_o, vec_sub_o}), 32'({p, s}));
            chk(32'(last_vec), 32'(v));
            wr(hi, bm);
            rd(hi, d);
            chk(d, persist(n) ? bm : 32'h0);
            @(posedge core_clk_i);
            src_req_i <= '0;
            wr(hi, bm);
            wr(hi + 8'h08, 32'h0);
            wr(pa, 32'h0);
        end
        wr(8'h10, 32'h1600_0000);
        wr(8'h14, 32'h1600_0000);
        wr(8'h08, 32'h0000_0108);
        @(posedge core_clk_i);
        src_req_i <= 39'h108;
        // flags land one edge later, the winner one edge after that
        @(posedge core_clk_i);
        rd(8'h30, d);
        chk(d, 32'h8000_2503);
        wr(8'h14, 32'h1700_0000);
        rd(8'h30, d);
        chk(d, 32'h8000_3507);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        src_req_i <= '0;
        rd(8'h08, d);
        chk(d, 32'h0);
        test_done();
    end
endmodule : irq_vector_mapping_tb
